/* dual_timer_counter_block.sv */
// What this block does
// - Timer 1 overflow sets flag; service clears
// - Timer 0 overflow sets flag; service clears
// - Run bit starts and stops each timer
// - Configured pin event sets external flag
// - Edge flag cleared on service; level follows
// - Type bit: one falling edge, zero low
// - Gate requires high interrupt pin to count
// - Counter select picks prescaled clock or fall
// - Mode 00: 8-bit count with 5-bit prescale
// - Mode 01: full 16-bit counter
// - Mode 10: low byte reloads from high
// - Mode 3 splits timer 0 in two
// - Timer 1 in mode 3 holds count
// - Fast clock bit picks divide 4 or 12
// - Timer 0 count readable as two bytes
// - Timer 1 count readable as two bytes
`timescale 1ns/1ps
module dual_timer_counter_block (
  input wire logic clk_in,              // System clock, 40 MHz
  input wire logic rst_b_in,            // Async reset, active low
  input wire logic [7:0] sfr_addr_in,   // Register address
  input wire logic sfr_wr_in,           // Write strobe
  input wire logic [7:0] sfr_wdata_in,  // Write data
  input wire logic sfr_rd_in,           // Read strobe
  output logic [7:0] sfr_rdata_out,     // Read data, one cycle later
  input wire logic t0_ack_in,           // Timer 0 service entered
  input wire logic t1_ack_in,           // Timer 1 service entered
  input wire logic ext0_ack_in,         // External 0 service vectored
  input wire logic ext1_ack_in,         // External 1 service vectored
  input wire logic t0_count_pin_in,     // Timer 0 count pin
  input wire logic t1_count_pin_in,     // Timer 1 count pin
  input wire logic ext_irq0_pin_in,     // External interrupt 0 pin
  input wire logic ext_irq1_pin_in,     // External interrupt 1 pin
  output logic timer0_irq_out,          // Timer 0 overflow flag
  output logic timer1_irq_out,          // Timer 1 overflow flag
  output logic ext0_irq_out,            // External 0 flag
  output logic ext1_irq_out             // External 1 flag
);
  import timer_pkg::*;

  timer_state_t st_r;
  timer_state_t st_nxt;
  logic [NUM_PINS-1:0] pin_s;
  logic [NUM_PINS-1:0] pin_fall;
  logic tick_fast;
  logic tick_slow;
  logic int_tick0;
  logic int_tick1;
  logic cnt0;
  logic cnt0_hi;
  logic cnt1;
  logic t0_set;
  logic t1_set;
  logic [16:0] step0;
  logic [16:0] step1;
  logic wr_ctl;
  logic wr_tl0;
  logic wr_th0;
  logic wr_tl1;
  logic wr_th1;

  // One step of a timer in modes 0 to 2; default is plain 8-bit low byte
  function automatic logic [16:0] timer_step(input mode_t m, input logic [7:0] tl,
                                             input logic [7:0] th);
    logic [8:0] hi;
    logic [16:0] r;
    hi = {1'b0, th} + 9'h001;
    r = {1'b0, th, tl};
    case (m)
      MODE_13BIT: begin
        if (tl[4:0] == 5'h1f) begin
          r = {hi[8], hi[7:0], tl[7:5], 5'h00};
        end else begin
          r = {1'b0, th, tl[7:5], 5'(tl[4:0] + 5'h01)};
        end
      end
      MODE_16BIT: begin
        r = {1'b0, th, tl} + 17'h0_0001;
      end
      MODE_RELOAD: begin
        if (tl == 8'hff) begin
          r = {1'b1, th, th};
        end else begin
          r = {1'b0, th, 8'(tl + 8'h01)};
        end
      end
      default: begin
        r = {&tl, th, 8'(tl + 8'h01)};
      end
    endcase
    return r;
  endfunction

  // Pins pass two flip-flops before any use
  pin_sync #(
    .WIDTH(NUM_PINS)
  ) pin_sync_inst (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .pins_in({ext_irq1_pin_in, ext_irq0_pin_in, t1_count_pin_in, t0_count_pin_in}),
    .pins_out(pin_s)
  );

  // Falling edges seen on the synchronised levels
  assign pin_fall = st_r.pin_prev & ~pin_s;

  // Divide-by-4 and divide-by-12 enables from one modulo-12 counter
  assign tick_slow = (st_r.div_cnt == 4'(DIV_SLOW - 1));
  assign tick_fast = (st_r.div_cnt[1:0] == 2'(DIV_FAST - 1));
  assign int_tick0 = st_r.clock_prescale_control[FAST_CLK0_BIT] ? tick_fast : tick_slow;
  assign int_tick1 = st_r.clock_prescale_control[FAST_CLK1_BIT] ? tick_fast : tick_slow;

  // Count enables: run bit, gate against the interrupt pin, clock source
  assign cnt0 = st_r.timer_control.timer0_run
    && (!st_r.timer_mode.t0.gate || pin_s[PIN_EXT0])
    && (st_r.timer_mode.t0.count_sel ? pin_fall[PIN_T0] : int_tick0);
  assign cnt1 = st_r.timer_control.timer1_run
    && (!st_r.timer_mode.t1.gate || pin_s[PIN_EXT1])
    && (st_r.timer_mode.t1.count_sel ? pin_fall[PIN_T1] : int_tick1)
    && (st_r.timer_mode.t1.mode != MODE_SPLIT);
  // Split high byte is a timer only, run by timer 1's run bit
  assign cnt0_hi = (st_r.timer_mode.t0.mode == MODE_SPLIT)
    && st_r.timer_control.timer1_run && int_tick0;

  assign step0 = timer_step(st_r.timer_mode.t0.mode, st_r.timer0_count_low,
                            st_r.timer0_count_high);
  assign step1 = timer_step(st_r.timer_mode.t1.mode, st_r.timer1_count_low,
                            st_r.timer1_count_high);

  // Overflow events; split mode lends timer 1's flag to timer 0's high byte
  assign t0_set = cnt0 && step0[16];
  assign t1_set = (cnt1 && step1[16] && (st_r.timer_mode.t0.mode != MODE_SPLIT))
    || (cnt0_hi && (st_r.timer0_count_high == 8'hff));

  // Address decode of the write strobe
  assign wr_ctl = sfr_wr_in && (sfr_addr_in == ADDR_TIMER_CONTROL);
  assign wr_tl0 = sfr_wr_in && (sfr_addr_in == ADDR_TIMER0_COUNT_LOW);
  assign wr_th0 = sfr_wr_in && (sfr_addr_in == ADDR_TIMER0_COUNT_HIGH);
  assign wr_tl1 = sfr_wr_in && (sfr_addr_in == ADDR_TIMER1_COUNT_LOW);
  assign wr_th1 = sfr_wr_in && (sfr_addr_in == ADDR_TIMER1_COUNT_HIGH);

  // Next state: counting first, software writes override counts,
  // hardware flag sets win over both acknowledges and writes
  always_comb begin
    st_nxt = st_r;
    st_nxt.pin_prev = pin_s;
    st_nxt.div_cnt = tick_slow ? RST_DIV : 4'(st_r.div_cnt + 4'h1);
    if (cnt0) begin
      st_nxt.timer0_count_low = step0[7:0];
      if (st_r.timer_mode.t0.mode != MODE_SPLIT) begin
        st_nxt.timer0_count_high = step0[15:8];
      end
    end
    if (cnt0_hi) begin
      st_nxt.timer0_count_high = 8'(st_r.timer0_count_high + 8'h01);
    end
    if (cnt1) begin
      st_nxt.timer1_count_low = step1[7:0];
      st_nxt.timer1_count_high = step1[15:8];
    end
    if (t0_ack_in) begin
      st_nxt.timer_control.timer0_overflow_flag = 1'b0;
    end
    if (t1_ack_in) begin
      st_nxt.timer_control.timer1_overflow_flag = 1'b0;
    end
    if (ext0_ack_in && st_r.timer_control.ext_irq0_type) begin
      st_nxt.timer_control.ext_irq0_flag = 1'b0;
    end
    if (ext1_ack_in && st_r.timer_control.ext_irq1_type) begin
      st_nxt.timer_control.ext_irq1_flag = 1'b0;
    end
    if (sfr_wr_in) begin
      case (sfr_addr_in)
        ADDR_TIMER_CONTROL: st_nxt.timer_control = timer_control_t'(sfr_wdata_in);
        ADDR_TIMER_MODE: st_nxt.timer_mode = timer_mode_t'(sfr_wdata_in);
        ADDR_TIMER0_COUNT_LOW: st_nxt.timer0_count_low = sfr_wdata_in;
        ADDR_TIMER0_COUNT_HIGH: st_nxt.timer0_count_high = sfr_wdata_in;
        ADDR_TIMER1_COUNT_LOW: st_nxt.timer1_count_low = sfr_wdata_in;
        ADDR_TIMER1_COUNT_HIGH: st_nxt.timer1_count_high = sfr_wdata_in;
        ADDR_CLOCK_PRESCALE_CONTROL: st_nxt.clock_prescale_control = sfr_wdata_in;
        default: st_nxt.rdata = st_r.rdata;
      endcase
    end
    if (t0_set) begin
      st_nxt.timer_control.timer0_overflow_flag = 1'b1;
    end
    if (t1_set) begin
      st_nxt.timer_control.timer1_overflow_flag = 1'b1;
    end
    // Level mode ignores writes: the flag simply mirrors a low pin
    if (st_nxt.timer_control.ext_irq0_type) begin
      if (pin_fall[PIN_EXT0]) begin
        st_nxt.timer_control.ext_irq0_flag = 1'b1;
      end
    end else begin
      st_nxt.timer_control.ext_irq0_flag = !pin_s[PIN_EXT0];
    end
    if (st_nxt.timer_control.ext_irq1_type) begin
      if (pin_fall[PIN_EXT1]) begin
        st_nxt.timer_control.ext_irq1_flag = 1'b1;
      end
    end else begin
      st_nxt.timer_control.ext_irq1_flag = !pin_s[PIN_EXT1];
    end
    // Registered read; the value reflects state before this cycle's update
    if (sfr_rd_in) begin
      case (sfr_addr_in)
        ADDR_TIMER_CONTROL: st_nxt.rdata = st_r.timer_control;
        ADDR_TIMER_MODE: st_nxt.rdata = st_r.timer_mode;
        ADDR_TIMER0_COUNT_LOW: st_nxt.rdata = st_r.timer0_count_low;
        ADDR_TIMER0_COUNT_HIGH: st_nxt.rdata = st_r.timer0_count_high;
        ADDR_TIMER1_COUNT_LOW: st_nxt.rdata = st_r.timer1_count_low;
        ADDR_TIMER1_COUNT_HIGH: st_nxt.rdata = st_r.timer1_count_high;
        ADDR_CLOCK_PRESCALE_CONTROL: st_nxt.rdata = st_r.clock_prescale_control;
        default: st_nxt.rdata = UNMAPPED_READ;
      endcase
    end
  end

  // State register
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st_r <= STATE_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the read data and flag flip-flops
  assign sfr_rdata_out = st_r.rdata;
  assign timer0_irq_out = st_r.timer_control.timer0_overflow_flag;
  assign timer1_irq_out = st_r.timer_control.timer1_overflow_flag;
  assign ext0_irq_out = st_r.timer_control.ext_irq0_flag;
  assign ext1_irq_out = st_r.timer_control.ext_irq1_flag;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_b_in);

  // Falling edge on the synchronised timer 1 pin
  sequence t1_fall_s;
    pin_s[PIN_T1] ##1 !pin_s[PIN_T1];
  endsequence

  // Timer 1 set up as a 16-bit event counter, undisturbed
  sequence t1_counting_s;
    st_r.timer_control.timer1_run && st_r.timer_mode.t1.count_sel
      && (!st_r.timer_mode.t1.gate || pin_s[PIN_EXT1])
      && (st_r.timer_mode.t1.mode == MODE_16BIT)
      && !wr_tl1 && !sfr_wr_in;
  endsequence

  t1_flag_set_a: assert property (t1_set |=> timer1_irq_out)
    else $error("timer 1 overflow did not set its flag");

  t1_flag_ack_a: assert property (t1_ack_in && !t1_set && !wr_ctl |=> !timer1_irq_out)
    else $error("timer 1 flag not cleared on service");

  t0_flag_set_a: assert property (t0_set |=> timer0_irq_out)
    else $error("timer 0 overflow did not set its flag");

  t0_flag_ack_a: assert property (t0_ack_in && !t0_set && !wr_ctl |=> !timer0_irq_out)
    else $error("timer 0 flag not cleared on service");

  t0_run_off_a: assert property (!st_r.timer_control.timer0_run && !wr_tl0
    |=> $stable(st_r.timer0_count_low))
    else $error("timer 0 low byte moved while stopped");

  ext0_edge_a: assert property (st_r.timer_control.ext_irq0_type && !wr_ctl
    && pin_fall[PIN_EXT0] |=> ext0_irq_out)
    else $error("falling edge did not set external 0 flag");

  ext1_level_a: assert property (!st_r.timer_control.ext_irq1_type && !wr_ctl
    |=> ext1_irq_out == !$past(pin_s[PIN_EXT1]))
    else $error("level flag does not follow the pin");

  t0_gate_a: assert property (st_r.timer_mode.t0.gate && !pin_s[PIN_EXT0] && !wr_tl0
    |=> $stable(st_r.timer0_count_low))
    else $error("gated timer 0 counted with pin low");

  t1_edge_count_a: assert property ((t1_fall_s ##0 t1_counting_s)
    |=> st_r.timer1_count_low == 8'($past(st_r.timer1_count_low) + 8'h01))
    else $error("timer 1 missed a count pin falling edge");

  t0_reload_a: assert property ((st_r.timer_mode.t0.mode == MODE_RELOAD) && cnt0
    && (st_r.timer0_count_low == 8'hff) && !wr_tl0
    |=> st_r.timer0_count_low == $past(st_r.timer0_count_high))
    else $error("mode 2 reload did not copy the high byte");

  t1_split_hold_a: assert property ((st_r.timer_mode.t1.mode == MODE_SPLIT) && !wr_tl1
    && !wr_th1 |=> $stable({st_r.timer1_count_high, st_r.timer1_count_low}))
    else $error("timer 1 counted in mode 3");

  slow_tick_a: assert property (tick_slow |-> ##12 tick_slow)
    else $error("divide by 12 enable period wrong");

  fast_tick_a: assert property (tick_fast |=> !tick_fast [*3] ##1 tick_fast)
    else $error("divide by 4 enable period wrong");

endmodule

/* pin_stimulus_model.sv */
`timescale 1ns/1ps
module pin_stimulus_model (
  input wire logic clk_in,        // System clock
  output logic t0_count_pin_out,  // Timer 0 count pin
  output logic t1_count_pin_out,  // Timer 1 count pin
  output logic ext_irq0_pin_out,  // External 0 pin
  output logic ext_irq1_pin_out   // External 1 pin
);
  // Idle high, where the pull-ups leave released pins
  initial begin
    t0_count_pin_out = 1'b1;
    t1_count_pin_out = 1'b1;
    ext_irq0_pin_out = 1'b1;
    ext_irq1_pin_out = 1'b1;
  end

  // One fall; each level held long enough for the two sync flops
  task automatic count_fall(input int which);
    @(negedge clk_in);
    if (which == 0) t0_count_pin_out = 1'b0;
    else t1_count_pin_out = 1'b0;
    repeat (4) @(negedge clk_in);
    if (which == 0) t0_count_pin_out = 1'b1;
    else t1_count_pin_out = 1'b1;
    repeat (4) @(negedge clk_in);
  endtask

  // Interrupt pin level, changed off the sampling edge
  task automatic set_ext(input int which, input logic lvl);
    @(negedge clk_in);
    if (which == 0) ext_irq0_pin_out = lvl;
    else ext_irq1_pin_out = lvl;
    repeat (3) @(negedge clk_in);
  endtask
endmodule

/* pin_sync.sv */
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 4
) (
  input wire logic clk_in,               // System clock
  input wire logic rst_b_in,             // Async reset, active low
  input wire logic [WIDTH-1:0] pins_in,  // Asynchronous pin levels
  output logic [WIDTH-1:0] pins_out      // Synchronised pin levels
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } sync_t;

  sync_t st_r;
  sync_t st_nxt;

  // Two stages; only the second stage is read outside
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = pins_in;
    st_nxt.s2 = st_r.s1;
  end

  // Pins idle high, so reset high avoids a false falling edge
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st_r <= '1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pins_out = st_r.s2;

endmodule

/* test_dual_timer_counter_block.sv */
`timescale 1ns/1ps
module test_dual_timer_counter_block;
  import timer_pkg::*;
  logic clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic [7:0] sfr_addr_in = 8'h00;
  logic sfr_wr_in = 1'b0;
  logic [7:0] sfr_wdata_in = 8'h00;
  logic sfr_rd_in = 1'b0;
  logic [7:0] sfr_rdata_out;
  logic [3:0] ack = 4'h0;
  wire [3:0] irqs;
  wire [3:0] pins;
  int bad_count = 0;
  int checks = 0;
  int cycles = 0;
  int n;
  logic [7:0] lo_a;
  logic [7:0] hi_a;

  always #12.5 clk_in = ~clk_in;

  dual_timer_counter_block dual_timer_counter_block_inst (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .sfr_addr_in(sfr_addr_in),
    .sfr_wr_in(sfr_wr_in), .sfr_wdata_in(sfr_wdata_in), .sfr_rd_in(sfr_rd_in),
    .sfr_rdata_out(sfr_rdata_out), .t0_ack_in(ack[0]), .t1_ack_in(ack[1]),
    .ext0_ack_in(ack[2]), .ext1_ack_in(ack[3]), .t0_count_pin_in(pins[0]),
    .t1_count_pin_in(pins[1]), .ext_irq0_pin_in(pins[2]), .ext_irq1_pin_in(pins[3]),
    .timer0_irq_out(irqs[0]), .timer1_irq_out(irqs[1]), .ext0_irq_out(irqs[2]),
    .ext1_irq_out(irqs[3]));

  pin_stimulus_model pin_stimulus_model_inst (
    .clk_in(clk_in), .t0_count_pin_out(pins[0]), .t1_count_pin_out(pins[1]),
    .ext_irq0_pin_out(pins[2]), .ext_irq1_pin_out(pins[3]));

  // Register port: strobe for one cycle, data lands the cycle after
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_in);
    sfr_addr_in = a;
    sfr_wdata_in = d;
    sfr_wr_in = 1'b1;
    @(negedge clk_in);
    sfr_wr_in = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_in);
    sfr_addr_in = a;
    sfr_rd_in = 1'b1;
    @(negedge clk_in);
    sfr_rd_in = 1'b0;
    d = sfr_rdata_out;
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp, input string what);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: %s got %b want %b", $time, what, got, exp);
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk8(d, exp, "register read");
  endtask

  task automatic ack_pulse(input int idx);
    @(negedge clk_in);
    ack = 4'(1 << idx);
    @(negedge clk_in);
    ack = 4'h0;
  endtask

  // Bounded wait, so a flag that never rises cannot hang the run
  task automatic wait_flag(input int idx, output int cnt);
    cnt = 0;
    while (irqs[idx] !== 1'b1 && cnt < 40) begin
      @(negedge clk_in);
      cnt++;
    end
  endtask

  task automatic results();
    $display("comparisons %0d, mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Hang guard; the whole sequence needs well under a thousand cycles
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      $display("unexpected at %0t: run did not finish", $time);
      results();
    end
  end

  initial begin
    repeat (6) @(negedge clk_in);
    rst_b_in = 1'b1;
    // Reset values, unmapped place, read/write of every register
    for (int a = 8'h88; a <= 8'h8e; a++) rchk(8'(a), 8'h00);
    wr(8'h8f, 8'h12);
    rchk(8'h8f, UNMAPPED_READ);
    for (int a = 8'h8a; a <= 8'h8d; a++) wr(8'(a), 8'(a + 8'h31));
    for (int a = 8'h8a; a <= 8'h8d; a++) rchk(8'(a), 8'(a + 8'h31));
    wr(ADDR_CLOCK_PRESCALE_CONTROL, 8'ha5);
    rchk(ADDR_CLOCK_PRESCALE_CONTROL, 8'ha5);
    wr(ADDR_TIMER_MODE, 8'h5c);
    rchk(ADDR_TIMER_MODE, 8'h5c);
    wr(ADDR_TIMER_CONTROL, 8'ha0);
    chk1(irqs[0], 1'b1, "soft set flag 0");
    chk1(irqs[1], 1'b1, "soft set flag 1");
    rchk(ADDR_TIMER_CONTROL, 8'ha0);
    wr(ADDR_TIMER_CONTROL, 8'h00);
    chk1(irqs[1], 1'b0, "soft clear flag 1");
    $display("test registers done");
    // Auto-reload, both dividers, service clearing, for each timer
    for (int t = 0; t < 2; t++) begin
      for (int f = 0; f < 2; f++) begin
        lo_a = t ? ADDR_TIMER1_COUNT_LOW : ADDR_TIMER0_COUNT_LOW;
        hi_a = t ? ADDR_TIMER1_COUNT_HIGH : ADDR_TIMER0_COUNT_HIGH;
        wr(ADDR_TIMER_CONTROL, 8'h00);
        wr(hi_a, 8'hff);
        wr(lo_a, 8'hfd);
        wr(ADDR_TIMER_MODE, t ? 8'h20 : 8'h02);
        wr(ADDR_CLOCK_PRESCALE_CONTROL, f ? (t ? 8'h10 : 8'h08) : 8'h00);
        wr(ADDR_TIMER_CONTROL, t ? 8'h40 : 8'h10);
        wait_flag(t, n);
        ack_pulse(t);
        chk1(irqs[t], 1'b0, "flag after service");
        wait_flag(t, n);
        chk8(8'(n), 8'((f ? DIV_FAST : DIV_SLOW) - 2), "cycles to next overflow");
        wr(ADDR_TIMER_CONTROL, 8'h00);
        rchk(lo_a, 8'hff);
        rchk(hi_a, 8'hff);
      end
    end
    $display("test reload and dividers done");
    // Mode 0 on timer 0 counting pin falls
    wr(ADDR_TIMER_MODE, 8'h04);
    wr(ADDR_TIMER0_COUNT_LOW, 8'hfe);
    wr(ADDR_TIMER0_COUNT_HIGH, 8'h00);
    wr(ADDR_TIMER_CONTROL, 8'h10);
    pin_stimulus_model_inst.count_fall(0);
    rchk(ADDR_TIMER0_COUNT_LOW, 8'hff);
    pin_stimulus_model_inst.count_fall(0);
    rchk(ADDR_TIMER0_COUNT_LOW, 8'he0);
    rchk(ADDR_TIMER0_COUNT_HIGH, 8'h01);
    wr(ADDR_TIMER0_COUNT_HIGH, 8'hff);
    wr(ADDR_TIMER0_COUNT_LOW, 8'h1f);
    pin_stimulus_model_inst.count_fall(0);
    chk1(irqs[0], 1'b1, "mode 0 overflow flag");
    rchk(ADDR_TIMER0_COUNT_HIGH, 8'h00);
    $display("test prescaled mode done");
    // Gated 16-bit counting on timer 1; timer 0 gated shut by a low pin
    wr(ADDR_TIMER_CONTROL, 8'h00);
    wr(ADDR_TIMER_MODE, 8'hd8);
    wr(ADDR_TIMER1_COUNT_LOW, 8'hfe);
    wr(ADDR_TIMER1_COUNT_HIGH, 8'h12);
    pin_stimulus_model_inst.set_ext(0, 1'b0);
    wr(ADDR_TIMER_CONTROL, 8'h50);
    pin_stimulus_model_inst.set_ext(1, 1'b0);
    pin_stimulus_model_inst.count_fall(1);
    rchk(ADDR_TIMER1_COUNT_LOW, 8'hfe);
    rchk(ADDR_TIMER0_COUNT_LOW, 8'h00);
    pin_stimulus_model_inst.set_ext(1, 1'b1);
    pin_stimulus_model_inst.count_fall(1);
    rchk(ADDR_TIMER1_COUNT_LOW, 8'hff);
    pin_stimulus_model_inst.count_fall(1);
    rchk(ADDR_TIMER1_COUNT_LOW, 8'h00);
    rchk(ADDR_TIMER1_COUNT_HIGH, 8'h13);
    pin_stimulus_model_inst.set_ext(0, 1'b1);
    $display("test gated counting done");
    // Level then falling-edge trigger on both external inputs
    for (int e = 0; e < 2; e++) begin
      wr(ADDR_TIMER_CONTROL, 8'h00);
      pin_stimulus_model_inst.set_ext(e, 1'b0);
      chk1(irqs[2 + e], 1'b1, "level flag");
      ack_pulse(2 + e);
      chk1(irqs[2 + e], 1'b1, "level flag after service");
      pin_stimulus_model_inst.set_ext(e, 1'b1);
      chk1(irqs[2 + e], 1'b0, "level flag follows pin");
      wr(ADDR_TIMER_CONTROL, e ? 8'h04 : 8'h01);
      pin_stimulus_model_inst.set_ext(e, 1'b0);
      pin_stimulus_model_inst.set_ext(e, 1'b1);
      chk1(irqs[2 + e], 1'b1, "edge flag held");
      ack_pulse(2 + e);
      chk1(irqs[2 + e], 1'b0, "edge flag after service");
    end
    $display("test external inputs done");
    // Split mode: high byte of timer 0 under timer 1 run, timer 1 frozen
    wr(ADDR_TIMER_CONTROL, 8'h00);
    wr(ADDR_TIMER0_COUNT_LOW, 8'h33);
    wr(ADDR_TIMER1_COUNT_LOW, 8'h55);
    wr(ADDR_TIMER0_COUNT_HIGH, 8'hff);
    wr(ADDR_TIMER_MODE, 8'h33);
    wr(ADDR_CLOCK_PRESCALE_CONTROL, 8'h08);
    wr(ADDR_TIMER_CONTROL, 8'h40);
    wait_flag(1, n);
    chk1(irqs[1], 1'b1, "split high byte overflow");
    chk1(irqs[0], 1'b0, "timer 0 flag idle");
    repeat (30) @(negedge clk_in);
    rchk(ADDR_TIMER1_COUNT_LOW, 8'h55);
    rchk(ADDR_TIMER0_COUNT_LOW, 8'h33);
    $display("test split mode done");
    results();
  end
endmodule

/* timer_pkg.sv */
package timer_pkg;

  // Register addresses on the special-function register port
  localparam logic [7:0] ADDR_TIMER_CONTROL = 8'h88;
  localparam logic [7:0] ADDR_TIMER_MODE = 8'h89;
  localparam logic [7:0] ADDR_TIMER0_COUNT_LOW = 8'h8a;
  localparam logic [7:0] ADDR_TIMER1_COUNT_LOW = 8'h8b;
  localparam logic [7:0] ADDR_TIMER0_COUNT_HIGH = 8'h8c;
  localparam logic [7:0] ADDR_TIMER1_COUNT_HIGH = 8'h8d;
  localparam logic [7:0] ADDR_CLOCK_PRESCALE_CONTROL = 8'h8e;

  // Unimplemented locations read high
  localparam logic [7:0] UNMAPPED_READ = 8'hff;

  // Reset values
  localparam logic [7:0] RST_TIMER_CONTROL = 8'h00;
  localparam logic [7:0] RST_TIMER_MODE = 8'h00;
  localparam logic [7:0] RST_COUNT = 8'h00;
  localparam logic [7:0] RST_CLOCK_PRESCALE_CONTROL = 8'h00;
  localparam logic [3:0] RST_DIV = 4'h0;
  localparam logic [3:0] RST_PINS = 4'hf;
  localparam logic [7:0] RST_RDATA = 8'h00;

  // Clock prescale control field positions
  localparam int FAST_CLK1_BIT = 4;
  localparam int FAST_CLK0_BIT = 3;

  // Internal count clock dividers
  localparam int DIV_FAST = 4;
  localparam int DIV_SLOW = 12;

  // Pin vector positions after synchronisation
  localparam int PIN_T0 = 0;
  localparam int PIN_T1 = 1;
  localparam int PIN_EXT0 = 2;
  localparam int PIN_EXT1 = 3;
  localparam int NUM_PINS = 4;

  typedef enum logic [1:0] {
    MODE_13BIT,
    MODE_16BIT,
    MODE_RELOAD,
    MODE_SPLIT
  } mode_t;

  typedef struct packed {
    logic timer1_overflow_flag;
    logic timer1_run;
    logic timer0_overflow_flag;
    logic timer0_run;
    logic ext_irq1_flag;
    logic ext_irq1_type;
    logic ext_irq0_flag;
    logic ext_irq0_type;
  } timer_control_t;

  typedef struct packed {
    logic gate;
    logic count_sel;
    mode_t mode;
  } mode_half_t;

  typedef struct packed {
    mode_half_t t1;
    mode_half_t t0;
  } timer_mode_t;

  typedef struct packed {
    timer_control_t timer_control;
    timer_mode_t timer_mode;
    logic [7:0] timer0_count_low;
    logic [7:0] timer0_count_high;
    logic [7:0] timer1_count_low;
    logic [7:0] timer1_count_high;
    logic [7:0] clock_prescale_control;
    logic [3:0] div_cnt;
    logic [3:0] pin_prev;
    logic [7:0] rdata;
  } timer_state_t;

  localparam timer_state_t STATE_RESET = {RST_TIMER_CONTROL, RST_TIMER_MODE, RST_COUNT,
    RST_COUNT, RST_COUNT, RST_COUNT, RST_CLOCK_PRESCALE_CONTROL, RST_DIV, RST_PINS,
    RST_RDATA};

endpackage
